// [src/reference_clock_output.sv]
/*
 * reference clock output: source select, power-of-two divider and
 * pin-select routing onto a set of remappable pins.
 * assumes the crystal and sleep inputs are asynchronous levels, the
 * pin-side gpio and analog enables are on clk, and the output is
 * sampled as a level (it toggles no faster than clk/2).
 */
`default_nettype none
// Notes on behaviour
// - enable bit 15 drives the reference clock out; clear disables it.
// - divider code n divides source by two to the power n; code 0 divides the system clock by two.
// - bit 14 and bits 7..0 of the control register read zero.
// - reference output has no fixed pin, only a mapped one.
// - unassigned remappable function drives no pin.
// - active remapped function beats other digital functions on its pin.
// - enabled analog function beats the remapped function.
// - input-only pins never receive the remapped output.
module reference_clock_output
	import ref_clock_pin_pkg::*;
(
	// clocking
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	// register port
	input  wire logic [3:0]          addr,
	input  wire logic [15:0]         wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic      [15:0]         rdata,
	// clock sources and power state
	input  wire logic                xtal_clk,
	input  wire logic                sleep,
	// per-pin competing functions
	input  wire logic [num_pins-1:0] gpio_out,
	input  wire logic [num_pins-1:0] gpio_oe,
	input  wire logic [num_pins-1:0] analog_en,
	// pins
	output logic      [num_pins-1:0] pin_out,
	output logic      [num_pins-1:0] pin_oe
);
	logic [15:0]          ctrl_q;
	logic [pin_idx_w-1:0] map_q;
	logic                 xtal_s, xtal_s_q, sleep_s;
	logic                 src_tick;
	logic [cnt_w-1:0]     cnt_q;
	logic                 ref_q;
	logic                 run;
	logic [div_w-1:0]     code;
	logic [cnt_w-1:0]     half;

	ref_clock_pin_sync u_xtal (.clk(clk), .rst_n(rst_n), .ce(ce),
		.d(xtal_clk), .q(xtal_s));
	ref_clock_pin_sync u_sleep (.clk(clk), .rst_n(rst_n), .ce(ce),
		.d(sleep), .q(sleep_s));

	assign code = ctrl_q[div_lsb +: div_w];
	// half period in source ticks minus one; code 0 has no half to count
	assign half = (code == 4'h0) ? '0 :
		cnt_w'((32'h1 << (code - 4'h1)) - 32'h1);
	// gate: enabled, and either awake or allowed to run in sleep
	assign run = ctrl_q[en_bit] && (!sleep_s || ctrl_q[slp_bit]);

	// control register; reserved bits never store (ctrl_wmask drops them on write)
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= ctrl_reset;
			map_q  <= pin_none;
		end else if (ce && wr) begin
			if (addr == ctrl_addr)
				ctrl_q <= wdata & ctrl_wmask;
			if (addr == pin_map_addr)
				map_q <= wdata[pin_idx_w-1:0];
		end
	end

	// read data the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (ce) begin
			if (!rd)
				rdata <= 16'h0000;
			else if (addr == ctrl_addr)
				rdata <= ctrl_q & ctrl_wmask;
			else if (addr == pin_map_addr)
				rdata <= {13'h0, map_q};
			else if (addr == status_addr)
				rdata <= {14'h0, run, ref_q};
			else
				rdata <= 16'h0000;
		end
	end

	// source ticks: crystal rising edges, or every system clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			xtal_s_q <= 1'b0;
		else if (ce)
			xtal_s_q <= xtal_s;
	end
	assign src_tick = ctrl_q[sel_bit] ? (xtal_s && !xtal_s_q)
		: 1'b1;

	// divider: toggle every 2^(n-1) ticks; code 0 follows the crystal or toggles every system clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			ref_q <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				cnt_q <= '0;
				ref_q <= 1'b0;
			end else if (code == 4'h0) begin
				cnt_q <= '0;
				ref_q <= ctrl_q[sel_bit] ? xtal_s : ~ref_q;
			end else if (src_tick) begin
				if (cnt_q >= half) begin
					cnt_q <= '0;
					ref_q <= ~ref_q;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end

	// pin-select priority: analog, then remapped output, then gpio
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else if (ce) begin
			for (int i = 0; i < num_pins; i++) begin
				if (analog_en[i]) begin
					pin_out[i] <= 1'b0;
					pin_oe[i]  <= 1'b0;
				end else if (map_q == pin_idx_w'(i) && run
					&& !input_only_pins[i]) begin
					pin_out[i] <= ref_q;
					pin_oe[i]  <= 1'b1;
				end else begin
					pin_out[i] <= gpio_out[i];
					pin_oe[i]  <= gpio_oe[i];
				end
			end
		end
	end

	// checks
	off_when_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !run |=> !ref_q)
		else $error("reference toggles while disabled");
	sleep_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && sleep_s && !ctrl_q[slp_bit] |=> !ref_q)
		else $error("reference runs in sleep");
	sys_div2_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && run && !ctrl_q[sel_bit] && code == 4'h0 && $past(run)
		&& $past(ce) |=> ref_q != $past(ref_q))
		else $error("undivided system clock not toggling");
	reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rd) && $past(addr) == ctrl_addr && $past(ce)
		|-> (rdata & ~ctrl_wmask) == 16'h0000)
		else $error("reserved bits read nonzero");
	analog_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && analog_en[0] |=> !pin_oe[0])
		else $error("analog pin driven");
	input_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && analog_en[3] == 1'b0 && gpio_oe[3] == 1'b0 |=> !pin_oe[3])
		else $error("input-only pin driven");
	unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && map_q == pin_none && gpio_oe == '0 |=> pin_oe == '0)
		else $error("unassigned function drives a pin");
	remap_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && run && map_q == 3'h1 && !analog_en[1]
		|=> pin_oe[1] && pin_out[1] == $past(ref_q))
		else $error("remapped output lost its pin");
	div16_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && run && !ctrl_q[sel_bit] && code == 4'h4
		&& $rose(ref_q) |=> (ref_q || !run) [*7])
		else $error("divide by 16 high phase short");
	xtal_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && run && ctrl_q[sel_bit] && code != 4'h0 && !src_tick
		|=> $stable(ref_q))
		else $error("crystal path toggled without a tick");
	run_cov_c: cover property (@(posedge clk) run && $rose(ref_q));
	xtal_cov_c: cover property (@(posedge clk) run && ctrl_q[sel_bit]);
	sleep_cov_c: cover property (@(posedge clk)
		run && sleep_s && ctrl_q[slp_bit]);
	pin_cov_c: cover property (@(posedge clk) |pin_oe && map_q != pin_none);
endmodule : reference_clock_output
`default_nettype wire

// [pkg/ref_clock_pin_pkg.sv]
/*
 * constants for the reference clock output block: control register layout,
 * reset value, divider geometry and the pin-select fabric sizing.
 * assumes a single 50 MHz clock domain and a plain strobe register port.
 */
`default_nettype none
package ref_clock_pin_pkg;
	localparam logic [3:0]  ctrl_addr       = 4'h0;  // control register
	localparam logic [3:0]  pin_map_addr    = 4'h1;  // target pin selector
	localparam logic [3:0]  status_addr     = 4'h2;  // live output state
	localparam int          en_bit          = 15;
	localparam int          slp_bit         = 13;
	localparam int          sel_bit         = 12;
	localparam int          div_lsb         = 8;
	localparam int          div_w           = 4;
	localparam logic [15:0] ctrl_wmask      = 16'hbf00;
	localparam logic [15:0] ctrl_reset      = 16'h0000;
	localparam int          cnt_w           = 15;
	localparam int          num_pins        = 4;
	localparam int          pin_idx_w       = 3;
	localparam logic [2:0]  pin_none        = 3'h7;  // unassigned
	localparam logic [num_pins-1:0] input_only_pins = 4'h8;
endpackage : ref_clock_pin_pkg
`default_nettype wire

// [src/ref_clock_pin_sync.sv]
/*
 * two flip-flop synchroniser for a single level from another domain.
 * assumes the input is a quasi-static level.
 */
`default_nettype none
module ref_clock_pin_sync (
	// clocking
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// level
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : ref_clock_pin_sync
`default_nettype wire

// [dv/ref_clock_pin_far_end.sv]
/* far end: crystal source and an observer of pin 1.
   assumes pin 1 has a pull-up while nobody drives it. */
`default_nettype none
module ref_clock_pin_far_end
	import ref_clock_pin_pkg::*;
(
	// clocking
	input  wire logic                clk,
	// pins
	input  wire logic [num_pins-1:0] pin_out,
	input  wire logic [num_pins-1:0] pin_oe,
	// crystal and measured period in clk cycles
	output logic                     xtal_clk,
	output int                       period
);
	logic lvl_q = 1'b1;
	int   cnt   = 0;
	// 10 MHz, under clk/4 so the synchroniser never misses an edge
	initial begin
		xtal_clk = 1'b0;
		#7;
		forever #50 xtal_clk = ~xtal_clk;
	end
	// cycles between rising edges of the resolved pin level
	always @(posedge clk) begin
		lvl_q <= pin_oe[1] ? pin_out[1] : 1'b1;
		cnt <= cnt + 1;
		if ((pin_oe[1] ? pin_out[1] : 1'b1) && !lvl_q) begin
			period <= cnt + 1;
			cnt <= 0;
		end
	end
endmodule : ref_clock_pin_far_end
`default_nettype wire

// [dv/reference_clock_output_tb.sv]
/* bench: register port, divider, pin priority, sleep, crystal.
   assumes a 50 MHz clock and the far-end model on pin 1. */
`default_nettype none
module reference_clock_output_tb import ref_clock_pin_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic                sleep = 1'b0, xtal_clk;
	logic [3:0]          addr = 4'h0;
	logic [15:0]         wdata = 16'h0000, rdata, d;
	logic [num_pins-1:0] gpio_out = '0, gpio_oe = '0, analog_en = '0;
	logic [num_pins-1:0] pin_out, pin_oe;
	int                  period, mismatches = 0, cmp_count = 0;
	// free-running system clock
	always #10 clk = ~clk;
	reference_clock_output u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.xtal_clk(xtal_clk), .sleep(sleep), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .analog_en(analog_en), .pin_out(pin_out),
		.pin_oe(pin_oe));
	ref_clock_pin_far_end u_far (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.xtal_clk(xtal_clk), .period(period));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task bus_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr
	// read data stands only in the cycle after the strobe
	task bus_rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : bus_rd
	task t_regs;
		bus_rd(ctrl_addr);
		chk(d, ctrl_reset);
		bus_rd(pin_map_addr);
		chk(d, {13'h0000, pin_none});
		bus_wr(ctrl_addr, 16'hffff);
		bus_rd(ctrl_addr);
		chk(d, 16'hbf00);
		bus_rd(4'hf);
		chk(d, 16'h0000);
		bus_wr(ctrl_addr, 16'h0000);
		$display("regs done");
	endtask : t_regs
	task t_div;
		int n;
		bus_wr(pin_map_addr, 16'h0001);
		for (n = 0; n < 7; n++) begin
			bus_wr(ctrl_addr, 16'h0000);
			bus_wr(ctrl_addr, {4'h8, n[3:0], 8'h00});
			repeat (8 << n) @(posedge clk);
			chk(period[15:0], n ? 16'h0001 << n : 16'h0002);
		end
		bus_wr(ctrl_addr, 16'h0000);
		repeat (4) @(posedge clk);
		bus_rd(status_addr);
		chk(d, 16'h0000);
		$display("divider done");
	endtask : t_div
	task t_pin;
		bus_wr(ctrl_addr, 16'h8000);
		gpio_oe <= 4'hf;
		gpio_out <= 4'h1;
		repeat (16) @(posedge clk);
		chk(period[15:0], 16'h0002);
		chk({pin_oe[0], pin_out[0]}, 16'h0003);
		chk({pin_oe[2], pin_out[2]}, 16'h0002);
		gpio_out <= 4'h0;
		analog_en <= 4'h2;
		repeat (4) @(posedge clk);
		chk(pin_oe[1], 1'b0);
		analog_en <= 4'h0;
		gpio_oe <= 4'h0;
		bus_wr(pin_map_addr, 16'h0003);
		repeat (8) @(posedge clk);
		chk(pin_oe, 4'h0);
		bus_wr(pin_map_addr, 16'h0007);
		repeat (8) @(posedge clk);
		chk(pin_oe, 4'h0);
		$display("pins done");
	endtask : t_pin
	task t_sleep;
		bus_wr(pin_map_addr, 16'h0001);
		sleep <= 1'b1;
		repeat (8) @(posedge clk);
		bus_rd(status_addr);
		chk(d[1], 1'b0);
		bus_wr(ctrl_addr, 16'ha000);
		repeat (8) @(posedge clk);
		bus_rd(status_addr);
		chk(d[1], 1'b1);
		sleep <= 1'b0;
		$display("sleep done");
	endtask : t_sleep
	task t_xtal;
		bus_wr(ctrl_addr, 16'h0000);
		bus_wr(ctrl_addr, 16'h9000);
		repeat (40) @(posedge clk);
		chk(period[15:0], 16'h0005);
		bus_wr(ctrl_addr, 16'h0000);
		bus_wr(ctrl_addr, 16'h9100);
		repeat (60) @(posedge clk);
		chk(period[15:0], 16'h000a);
		$display("crystal done");
	endtask : t_xtal
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// main sequence after 16 cycles of reset
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_div;
		t_pin;
		t_sleep;
		t_xtal;
		print_verdict;
	end
	// the tests need about 1300 cycles; a hang ends the run
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		print_verdict;
	end
endmodule : reference_clock_output_tb
`default_nettype wire
